// ==== psa_sram_top.sv ====
`timescale 1ns/1ps
module psa_sram_top
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [psa_pkg::ADDR_W-1:0] addr_in,
    input wire logic chip_sel_first_n_in,
    input wire logic chip_sel_second_in,
    input wire logic chip_sel_third_n_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic global_write_n_in,
    input wire logic byte_write_enable_n_in,
    input wire logic [psa_pkg::LANES-1:0] byte_lane_select_n_in,
    input wire logic burst_order_in,
    input wire logic output_enable_n_in,
    input wire logic [psa_pkg::DATA_W-1:0] data_io_in,
    input wire logic [psa_pkg::PAR_W-1:0] parity_io_in,
    output logic [psa_pkg::DATA_W-1:0] data_io_out,
    output logic [psa_pkg::PAR_W-1:0] parity_io_out,
    output logic data_io_oe_out
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    psa_mem_if mif ();
    psa_pkg::psa_state_e state_reg;
    psa_pkg::psa_state_e state_next;
    logic [psa_pkg::ADDR_W-1:psa_pkg::BURST_W] addr_hi_reg;
    logic [psa_pkg::DATA_W-1:0] data_out_reg;
    logic [psa_pkg::PAR_W-1:0] parity_out_reg;
    logic oe_reg;
    logic rd_pipe_reg;
    logic first_reg;
    logic selected;
    logic proc_addr_strobe_n_act;
    logic ctrl_addr_strobe_n_act;
    logic strobe;
    logic start;
    logic desel;
    logic cont;
    logic write_req;
    logic wr_now;
    logic rd_now;
    logic linear;
    logic [psa_pkg::LANES-1:0] lane_we;
    logic [psa_pkg::BURST_W-1:0] burst_cur;
    logic [psa_pkg::BURST_W-1:0] burst_next;
    logic [psa_pkg::WORD_W-1:0] lane_wdata;

    // ------------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------------

    // All inputs are already synchronous; they are decoded at the edge itself.
    assign selected = !chip_sel_first_n_in && chip_sel_second_in && !chip_sel_third_n_in;
    assign proc_addr_strobe_n_act = !proc_addr_strobe_n_in && !chip_sel_first_n_in;
    assign ctrl_addr_strobe_n_act = !ctrl_addr_strobe_n_in && !proc_addr_strobe_n_act;
    assign strobe = proc_addr_strobe_n_act || ctrl_addr_strobe_n_act;
    assign start = strobe && selected;
    assign desel = strobe && !selected;
    assign cont = !strobe && (state_reg != psa_pkg::PSA_ST_DESEL);
    assign linear = (burst_order_in == psa_pkg::ORDER_LINEAR);

    // Global write wins over the byte controls; otherwise, with byte write enable low, lanes follow selects.
    always_comb
    begin
        if (!global_write_n_in)
        begin
            lane_we = psa_pkg::ALL_LANES;
        end
        else if (!byte_write_enable_n_in)
        begin
            lane_we = ~byte_lane_select_n_in;
        end
        else
        begin
            lane_we = psa_pkg::NO_LANES;
        end
    end

    assign write_req = |lane_we;

    // A processor-strobe start never writes in its own cycle; the write, if
    // any, is the continuation cycle that follows it.
    assign wr_now = (start && ctrl_addr_strobe_n_act && write_req) || (cont && write_req);
    assign rd_now = (start && !(ctrl_addr_strobe_n_act && write_req)) || (cont && !write_req);

    // ------------------------------------------------------------------------
    // Address path and burst counter
    // ------------------------------------------------------------------------
    psa_burst_ctr u_burst
    (
        .clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .load_in(start),
        .start_in(addr_in[psa_pkg::BURST_W-1:0]),
        .step_in(cont && !burst_advance_n_in),
        .linear_in(linear),
        .cur_out(burst_cur),
        .next_out(burst_next)
    );

    // The upper address bits are held for the life of the burst.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            addr_hi_reg <= '0;
        end
        else if (start)
        begin
            addr_hi_reg <= addr_in[psa_pkg::ADDR_W-1:psa_pkg::BURST_W];
        end
    end

    // A start presents the external address straight to the array; in a
    // burst, advance picks the next or the current (repeated) address.
    always_comb
    begin
        if (start)
        begin
            mif.addr = addr_in;
        end
        else if (!burst_advance_n_in)
        begin
            mif.addr = {addr_hi_reg, burst_next};
        end
        else
        begin
            mif.addr = {addr_hi_reg, burst_cur};
        end
    end

    // Lane k carries its parity bit above its eight data bits.
    always_comb
    begin
        lane_wdata = '0;
        for (int k = 0; k < psa_pkg::LANES; k++)
        begin
            lane_wdata[k*psa_pkg::LANE_W +: psa_pkg::LANE_W] =
                {parity_io_in[k], data_io_in[k*psa_pkg::LANE_DATA_W +: psa_pkg::LANE_DATA_W]};
        end
    end

    assign mif.wdata = lane_wdata;
    assign mif.byte_we = wr_now ? lane_we : psa_pkg::NO_LANES;
    assign mif.rd_en = rd_now;

    psa_mem_array u_array
    (
        .clk_in(ref_clk_in),
        .mem(mif.array)
    );

    // ------------------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------------------

    // The state remembers whether a burst is open and what it last did.
    always_comb
    begin
        case (state_reg)
            psa_pkg::PSA_ST_DESEL,
            psa_pkg::PSA_ST_READ,
            psa_pkg::PSA_ST_WRITE:
            begin
                if (desel)
                begin
                    state_next = psa_pkg::PSA_ST_DESEL;
                end
                else if (wr_now)
                begin
                    state_next = psa_pkg::PSA_ST_WRITE;
                end
                else if (rd_now)
                begin
                    state_next = psa_pkg::PSA_ST_READ;
                end
                else
                begin
                    state_next = state_reg;
                end
            end
            default:
            begin
                state_next = psa_pkg::PSA_ST_DESEL;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= psa_pkg::PSA_ST_DESEL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------------

    // Marks that the array read at the last edge is now in the output stage,
    // and whether that access opened from the deselected state.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_pipe_reg <= 1'b0;
            first_reg <= 1'b0;
        end
        else
        begin
            rd_pipe_reg <= rd_now;
            first_reg <= start && (state_reg == psa_pkg::PSA_ST_DESEL);
        end
    end

    // Output registers; a suspended read simply reloads the same word.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            data_out_reg <= psa_pkg::DATA_RESET;
            parity_out_reg <= psa_pkg::PAR_RESET;
        end
        else if (rd_pipe_reg)
        begin
            for (int k = 0; k < psa_pkg::LANES; k++)
            begin
                data_out_reg[k*psa_pkg::LANE_DATA_W +: psa_pkg::LANE_DATA_W] <=
                    mif.rdata[k*psa_pkg::LANE_W +: psa_pkg::LANE_DATA_W];
                parity_out_reg[k] <= mif.rdata[k*psa_pkg::LANE_W + psa_pkg::LANE_DATA_W];
            end
        end
    end

    // Output enable is sampled with the clock so the pin enable comes from a
    // flip-flop; the cost is one cycle of extra turn-on and turn-off delay.
    // A deselect stops new reads, so the last word stays out one more cycle.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            oe_reg <= 1'b0;
        end
        else if (wr_now)
        begin
            oe_reg <= 1'b0;
        end
        else if (first_reg)
        begin
            // The first word after leaving the deselected state stays off the pins.
            oe_reg <= 1'b0;
        end
        else
        begin
            oe_reg <= rd_pipe_reg && !output_enable_n_in;
        end
    end

    assign data_io_out = data_out_reg;
    assign parity_io_out = parity_out_reg;
    assign data_io_oe_out = oe_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_read_drive;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (rd_now && state_reg != psa_pkg::PSA_ST_DESEL) ##1 (!output_enable_n_in && !wr_now)
            |=> data_io_oe_out;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    property p_write_release;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr_now |=> !data_io_oe_out;
    endproperty
    a_write_release: assert property (p_write_release)
        else $error("pins driven on write");

    property p_proc_strobe_ignored;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (chip_sel_first_n_in && ctrl_addr_strobe_n_in && state_reg == psa_pkg::PSA_ST_DESEL)
            |=> (state_reg == psa_pkg::PSA_ST_DESEL);
    endproperty
    a_proc_strobe_ignored: assert property (p_proc_strobe_ignored)
        else $error("strobe taken");

    property p_double_deselect;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        desel ##1 (!start && !rd_now) |=> !data_io_oe_out;
    endproperty
    a_double_deselect: assert property (p_double_deselect) else $error("late release");

    property p_global_all;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_now && !global_write_n_in) |-> (mif.byte_we == psa_pkg::ALL_LANES);
    endproperty
    a_global_all: assert property (p_global_all) else $error("global write not full");

    property p_byte_lanes;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (wr_now && global_write_n_in) |-> (mif.byte_we == ~byte_lane_select_n_in);
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("wrong byte lanes");

    property p_proc_first_no_write;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (start && proc_addr_strobe_n_act) |-> (mif.byte_we == psa_pkg::NO_LANES)
            ##1 (state_reg == psa_pkg::PSA_ST_READ);
    endproperty
    a_proc_first_no_write: assert property (p_proc_first_no_write)
        else $error("early write");

    property p_both_strobes;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (!proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in && selected) |-> !wr_now;
    endproperty
    a_both_strobes: assert property (p_both_strobes)
        else $error("controller strobe acted");

    property p_hold_addr;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (rd_now || wr_now) ##1 (cont && burst_advance_n_in) |-> (mif.addr == $past(mif.addr));
    endproperty
    a_hold_addr: assert property (p_hold_addr) else $error("suspend moved address");

    property p_linear_step;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (rd_now || wr_now) ##1 (cont && !burst_advance_n_in && linear)
            |-> (mif.addr[1:0] == 2'($past(mif.addr[1:0]) + 2'h1));
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

    property p_first_masked;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (start && state_reg == psa_pkg::PSA_ST_DESEL) |=> !data_io_oe_out ##1 !data_io_oe_out;
    endproperty
    a_first_masked: assert property (p_first_masked) else $error("first cycle driven");

    property p_four_beat;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (start && rd_now) ##1 (cont && rd_now && !burst_advance_n_in) [*3];
    endproperty
    c_four_beat: cover property (p_four_beat);

    property p_ctrl_write;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        start && ctrl_addr_strobe_n_act && wr_now;
    endproperty
    c_ctrl_write: cover property (p_ctrl_write);

    property p_proc_write;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (start && proc_addr_strobe_n_act) ##1 wr_now;
    endproperty
    c_proc_write: cover property (p_proc_write);

    property p_deselect;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        rd_now ##1 desel;
    endproperty
    c_deselect: cover property (p_deselect);
endmodule // psa_sram_top

// ==== psa_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants of the pipelined burst SRAM access logic.
// ----------------------------------------------------------------------------
package psa_pkg;

    // Array geometry: four byte lanes of eight data bits plus one parity bit.
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int LANES = 4;
    localparam int LANE_DATA_W = 8;
    localparam int LANE_W = 9;
    localparam int WORD_W = 36;
    localparam int DEPTH = 524288;
    localparam int BURST_W = 2;

    // Burst order strap levels.
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    // Reset values of the output stage and burst counter, and the all-lanes and no-lanes write masks.
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [PAR_W-1:0] PAR_RESET = 4'h0;
    localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
    localparam logic [LANES-1:0] ALL_LANES = 4'hF;
    localparam logic [LANES-1:0] NO_LANES = 4'h0;

    // Access state, one-hot.
    typedef enum logic [2:0]
    {
        PSA_ST_DESEL = 3'h1,
        PSA_ST_READ = 3'h2,
        PSA_ST_WRITE = 3'h4
    } psa_state_e;

endpackage

// ==== psa_mem_if.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port between the access control and the storage array.
// ----------------------------------------------------------------------------
interface psa_mem_if;
    logic [psa_pkg::ADDR_W-1:0] addr;
    logic [psa_pkg::WORD_W-1:0] wdata;
    logic [psa_pkg::LANES-1:0] byte_we;
    logic rd_en;
    logic [psa_pkg::WORD_W-1:0] rdata;

    modport ctrl (output addr, output wdata, output byte_we, output rd_en, input rdata);
    modport array (input addr, input wdata, input byte_we, input rd_en, output rdata);
endinterface

// ==== psa_burst_ctr.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Two-bit wraparound burst counter.
// ----------------------------------------------------------------------------
module psa_burst_ctr
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [psa_pkg::BURST_W-1:0] start_in,
    input wire logic step_in,
    input wire logic linear_in,
    output logic [psa_pkg::BURST_W-1:0] cur_out,
    output logic [psa_pkg::BURST_W-1:0] next_out
);
    logic [psa_pkg::BURST_W-1:0] start_reg;
    logic [psa_pkg::BURST_W-1:0] cnt_reg;
    logic [psa_pkg::BURST_W-1:0] cnt_next;

    // Start value and count are kept apart so either order is a pure function.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            start_reg <= psa_pkg::BURST_RESET;
            cnt_reg <= psa_pkg::BURST_RESET;
        end
        else if (load_in)
        begin
            start_reg <= start_in;
            cnt_reg <= psa_pkg::BURST_RESET;
        end
        else if (step_in)
        begin
            cnt_reg <= cnt_next;
        end
    end

    // The count wraps naturally in two bits.
    assign cnt_next = 2'(cnt_reg + 2'h1);

    // Interleaved uses exclusive-or, linear adds modulo four.
    assign cur_out = linear_in ? 2'(start_reg + cnt_reg) : (start_reg ^ cnt_reg);
    assign next_out = linear_in ? 2'(start_reg + cnt_next) : (start_reg ^ cnt_next);

    property p_load_seed;
        @(posedge clk_in) disable iff (!arst_n_in)
        load_in |=> (cur_out == $past(start_in));
    endproperty
    a_load_seed: assert property (p_load_seed) else $error("burst start not seeded");
endmodule // psa_burst_ctr

// ==== psa_mem_array.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Storage array with per-lane write and registered read.
// ----------------------------------------------------------------------------
module psa_mem_array
(
    input wire logic clk_in,
    psa_mem_if.array mem
);
    logic [psa_pkg::WORD_W-1:0] store [0:psa_pkg::DEPTH-1];
    logic [psa_pkg::WORD_W-1:0] rdata_reg;

    // Only enabled lanes change; the others keep their old contents.
    always_ff @(posedge clk_in)
    begin
        for (int k = 0; k < psa_pkg::LANES; k++)
        begin
            if (mem.byte_we[k])
            begin
                store[mem.addr][k*psa_pkg::LANE_W +: psa_pkg::LANE_W] <=
                    mem.wdata[k*psa_pkg::LANE_W +: psa_pkg::LANE_W];
            end
        end
    end

    // Read stage: the address is applied in the cycle it arrives.
    always_ff @(posedge clk_in)
    begin
        if (mem.rd_en)
        begin
            rdata_reg <= store[mem.addr];
        end
    end

    assign mem.rdata = rdata_reg;
endmodule // psa_mem_array

// ==== psa_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bus master side of the shared data and parity pins.
// ----------------------------------------------------------------------------
module psa_host_model
(
    input wire logic ref_clk_in,
    input wire logic output_enable_n_in,
    input wire logic drive_in,
    input wire logic [psa_pkg::WORD_W-1:0] word_in,
    input wire logic dut_oe_in,
    input wire logic [psa_pkg::WORD_W-1:0] dut_word_in,
    output logic [psa_pkg::WORD_W-1:0] pin_out
);
    logic [psa_pkg::WORD_W-1:0] last_reg = 36'h0_0000_0000;

    // Undriven pins show the inverse of the last level, so a stale word is not seen in the first undriven cycle.
    always_comb
    begin
        if (drive_in && output_enable_n_in)
            pin_out = word_in;
        else if (dut_oe_in)
            pin_out = dut_word_in;
        else
            pin_out = ~last_reg;
    end

    // Last wire level, kept only to invert it while the pins float.
    always_ff @(posedge ref_clk_in)
        last_reg <= pin_out;
endmodule // psa_host_model

// ==== psa_sram_top_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench of the burst SRAM access logic.
// ----------------------------------------------------------------------------
module psa_sram_top_test;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [35:0] NONE = 36'h0_0000_0000;
    logic clk, rst_n, p_n, c_n, adv_n, gw_n, bwe_n, order, oe_n, drive, dq_oe;
    logic [2:0] cs, m, s, k, pv = 3'h0, pov = 3'h0, po = 3'h0;
    logic [3:0] bl, dp, b;
    logic [18:0] addr, base, i;
    logic [31:0] dq;
    logic [31:0] seed = 32'hc861_611f;
    logic [35:0] word, pin, d;
    logic [35:0] pd [3];
    logic [35:0] mem [logic [18:0]];
    logic [1:0] ad;
    int errors = 0;
    int total_checks = 0;

    psa_sram_top u_dut (.ref_clk_in(clk), .arst_n_in(rst_n), .addr_in(addr),
        .chip_sel_first_n_in(cs[2]), .chip_sel_second_in(cs[1]), .chip_sel_third_n_in(cs[0]),
        .proc_addr_strobe_n_in(p_n), .ctrl_addr_strobe_n_in(c_n), .burst_advance_n_in(adv_n),
        .global_write_n_in(gw_n), .byte_write_enable_n_in(bwe_n), .byte_lane_select_n_in(bl),
        .burst_order_in(order), .output_enable_n_in(oe_n), .data_io_in(pin[31:0]),
        .parity_io_in(pin[35:32]), .data_io_out(dq), .parity_io_out(dp), .data_io_oe_out(dq_oe));
    psa_host_model u_host (.ref_clk_in(clk), .output_enable_n_in(oe_n), .drive_in(drive),
        .word_in(word), .dut_oe_in(dq_oe), .dut_word_in({dp, dq}), .pin_out(pin));

    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed;
    endfunction

    function logic [35:0] rword();
        logic [31:0] h;
        h = rnd();
        return {h[3:0], rnd()};
    endfunction

    // Expected array word after a write; lane k is data byte k plus parity bit k.
    function logic [35:0] merge(input logic [35:0] o, n, input logic gw, byte_write_enable_n,
        input logic [3:0] bs);
        for (int j = 0; j < 4; j++)
        begin
            if (!gw || (!byte_write_enable_n && !bs[j]))
            begin
                o[8*j+:8] = n[8*j+:8];
                o[32+j] = n[32+j];
            end
        end
        return o;
    endfunction

    task check(input logic [35:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; what a read launched now should show is checked three edges later.
    task op(input logic p, c, input logic [2:0] sl, input logic burst_advance_n, gw, byte_write_enable_n,
        input logic [3:0] bs, input logic [18:0] a, input logic [35:0] dw,
        input logic ev, eov, eo, input logic [35:0] ew);
        logic wv;
        @(posedge clk);
        if (pv[0])
            check({dp, dq}, pd[0]);
        if (pov[0])
            check(36'(dq_oe), 36'(po[0]));
        pv = {ev, pv[2:1]};
        pov = {eov, pov[2:1]};
        po = {eo, po[2:1]};
        pd[0] = pd[1];
        pd[1] = pd[2];
        pd[2] = ew;
        wv = (!gw || (!byte_write_enable_n && bs != 4'hF)) && !(!p && !sl[2]);
        p_n <= p;
        c_n <= c;
        cs <= sl;
        adv_n <= burst_advance_n;
        gw_n <= gw;
        bwe_n <= byte_write_enable_n;
        bl <= bs;
        addr <= a;
        oe_n <= wv;
        drive <= wv;
        word <= dw;
    endtask

    task rd(input logic p, input logic [18:0] a, input logic eo);
        op(!p, p, SEL, 1'b1, 1'b1, 1'b1, 4'hF, a, NONE, 1'b1, 1'b1, eo, mem[a]);
    endtask

    task wr(input logic [18:0] a, input logic gw, byte_write_enable_n, input logic [3:0] bs, input logic chk);
        logic [35:0] dw;
        dw = rword();
        op(1'b1, 1'b0, SEL, seed[5], gw, byte_write_enable_n, bs, a, dw, 1'b0, chk, 1'b0, NONE);
        mem[a] = merge(mem.exists(a) ? mem[a] : NONE, dw, gw, byte_write_enable_n, bs);
    endtask

    task desel(input logic chk);
        op(1'b1, 1'b0, 3'h6, 1'b1, 1'b1, 1'b1, 4'hF, 19'h0_0000, NONE, 1'b0, chk, 1'b0,
            NONE);
    endtask

    task final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 133 cycles.
    initial
    begin
        repeat (4000) @(posedge clk);
        errors++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        {rst_n, p_n, c_n, adv_n, gw_n, bwe_n, order, oe_n, drive} = 9'h0FE;
        {cs, bl, addr, word} = {3'h6, 4'hF, 19'h0_0000, NONE};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        void'(rnd());
        base = {seed[18:3], 3'h0};
        for (i = 0; i < 8; i++)
            wr(base + i, 1'b0, seed[0], seed[4:1], i != 7);
        desel(1'b0);
        for (i = 0; i < 8; i++)
            rd(i[0], base + i, i != 0 && i != 7);
        d = rword();
        op(1'b0, 1'b1, 3'h6, 1'b1, 1'b0, 1'b1, 4'hF, base, d, 1'b0, 1'b0, 1'b0, NONE);
        mem[base + 7] = d;
        op(1'b0, 1'b0, SEL, 1'b1, 1'b0, 1'b0, 4'h0, base, NONE, 1'b1, 1'b1, 1'b1,
            mem[base]);
        desel(1'b1);
        $display("global write and single read test done");
        for (i = 0; i < 4; i++)
        begin
            void'(rnd());
            b = (seed[3:0] == 4'hF) ? 4'h6 : seed[3:0];
            wr(base + i, 1'b1, 1'b0, i == 0 ? 4'h0 : b, i != 3);
        end
        for (i = 4; i < 6; i++)
        begin
            d = rword();
            op(1'b0, 1'b1, SEL, 1'b0, 1'b0, 1'b0, 4'h0, base + i, NONE, 1'b0, 1'b0, 1'b0,
                NONE);
            op(1'b1, 1'b1, SEL, 1'b1, i[0], 1'b0, seed[3:0], base + i, d, 1'b0, 1'b0, 1'b0,
                NONE);
            mem[base + i] = merge(mem[base + i], d, i[0], 1'b0, seed[3:0]);
        end
        desel(1'b0);
        for (i = 0; i < 8; i++)
            rd(i[0], base + i, i != 0);
        desel(1'b1);
        $display("byte write test done");
        for (m = 0; m < 2; m++)
        begin
            for (s = 0; s < 4; s++)
            begin
                order <= m[0];
                rd(s[0], {base[18:2], s[1:0]}, 1'b0);
                for (k = 1; k < 5; k++)
                begin
                    // The last beat holds advance high and repeats the address before it.
                    ad = (k == 4) ? 2'h3 : k[1:0];
                    ad = m[0] ? s[1:0] ^ ad : 2'(s[1:0] + ad);
                    op(1'b1, 1'b1, SEL, k == 4, 1'b1, 1'b1, 4'hF, base, NONE, 1'b1, 1'b1,
                        1'b1, mem[{base[18:2], ad}]);
                end
                desel(1'b1);
            end
        end
        $display("burst test done");
        for (i = 0; i < 8; i++)
        begin
            op(1'b1, 1'b0, i[2:0], 1'b1, 1'b1, 1'b1, 4'hF, base, NONE, 1'b0, 1'b1, 1'b0,
                NONE);
            op(1'b1, 1'b1, SEL, 1'b1, 1'b1, 1'b1, 4'hF, base, NONE, i == 2, 1'b1, i == 2,
                mem[base]);
            desel(1'b1);
        end
        $display("chip select test done");
        repeat (3) desel(1'b0);
        final_report();
    end
endmodule // psa_sram_top_test
